// >>> rib_map.svh
`ifndef RIB_MAP_SVH
`define RIB_MAP_SVH
// register byte offsets
`define RIB_A_CMD 8'h00
`define RIB_A_RXBUF 8'h04
`define RIB_A_STAT 8'h08
`define RIB_A_RESP 8'h0C
`define RIB_A_ERRLOG 8'h10
`define RIB_A_STB 8'h14
// command register fields
`define RIB_F_OP 3:0
`define RIB_F_ARG 15:8
// status register fields; bit 31 is the valid flag of the input buffer register
`define RIB_F_FILL 7:0
`define RIB_F_XOFF 8
`define RIB_F_BUSY 9
`define RIB_F_RMT 11:10
`define RIB_F_MAV 12
`define RIB_F_RXVLD 31
// input buffer and flow control levels
`define RIB_IB_DEPTH 250
`define RIB_XOFF_LVL (`RIB_IB_DEPTH * 80 / 100)
`define RIB_XON_LVL (`RIB_IB_DEPTH * 40 / 100)
`define RIB_CH_XOFF 8'h13
`define RIB_CH_XON 8'h11
// error queue
`define RIB_EQ_DEPTH 15
`define RIB_ERR_OVF 16'h0001
`define RIB_ERR_SER_OVF 16'h0078
// status byte and event bit positions
`define RIB_B_MAV 4
`define RIB_B_ESB 5
`define RIB_B_RQS 6
`define RIB_B_OPC 0
// reset values
`define RIB_RST_BYTE 8'h00
`define RIB_RST_WORD 32'h0000_0000
// arbitrary identification word, not tied to any maker
`define RIB_ID_WORD 32'h0000_A5C3
`endif

// >>> rib_pkg.sv
`include "rib_map.svh"
package rib_pkg;
	// command opcodes written to the command register
	typedef enum logic [3:0] {
		RIB_OP_CLS = 4'h0, RIB_OP_ESE = 4'h1, RIB_OP_ESEQ = 4'h2, RIB_OP_ESRQ = 4'h3,
		RIB_OP_IDNQ = 4'h4, RIB_OP_OPC = 4'h5, RIB_OP_OPCQ = 4'h6, RIB_OP_RST = 4'h7,
		RIB_OP_SRE = 4'h8, RIB_OP_SREQ = 4'h9, RIB_OP_TSTQ = 4'hA, RIB_OP_WAI = 4'hB,
		RIB_OP_FLTQ = 4'hC, RIB_OP_LOC = 4'hD, RIB_OP_LLO = 4'hE, RIB_OP_RMT = 4'hF
	} rib_op_t;
	typedef enum logic [2:0] {
		RIB_ST_IDLE = 3'b000, RIB_ST_WAIT = 3'b001, RIB_ST_OPCQ = 3'b010,
		RIB_ST_RESET = 3'b011, RIB_ST_TEST = 3'b100
	} rib_st_t;
	typedef enum logic [1:0] {
		RIB_RM_LOCAL = 2'b00, RIB_RM_REMOTE = 2'b01, RIB_RM_LOCKOUT = 2'b10
	} rib_rmt_t;
	// input buffer entry: marker set means end-of-message marker
	typedef struct packed {
		logic mark;
		logic [7:0] data;
	} rib_ent_t;
	typedef struct packed {
		logic [`RIB_IB_DEPTH-1:0][8:0] mem;
		logic [7:0] wr;
		logic [7:0] rd;
		logic [7:0] cnt;
	} rib_fifo_s_t;
	typedef struct packed {
		logic [15:0][15:0] mem;
		logic [3:0] wr;
		logic [3:0] rd;
		logic [4:0] cnt;
	} rib_eq_s_t;
	typedef struct packed {
		logic [7:0] ese;
		logic [7:0] sre;
		logic [7:0] esr;
		logic rqs;
		logic opc_arm;
		logic mav;
		logic [31:0] resp;
		rib_st_t st;
		rib_rmt_t rmt;
		logic eoi_pend;
		logic xoff;
		logic tx_vld;
		logic [7:0] tx;
		logic st_go;
		logic rst_go;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
	} rib_top_s_t;
endpackage

// >>> rib_fifo.sv
`include "rib_map.svh"
module rib_fifo (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic clr_i,
	input wire logic push_i,
	input wire rib_pkg::rib_ent_t din_i,
	input wire logic pop_i,
	output rib_pkg::rib_ent_t dout_o,
	output logic [7:0] cnt_o,
	output logic full_o,
	output logic empty_o
);
	import rib_pkg::*;
	localparam logic [7:0] LAST = 8'(`RIB_IB_DEPTH - 1);
	rib_fifo_s_t s_q, s_d;

	// pushes into a full buffer and pops of an empty one are dropped
	always_comb begin
		logic do_push;
		logic do_pop;
		do_push = push_i && !full_o;
		do_pop = pop_i && !empty_o;
		s_d = s_q;
		if (do_push) begin
			s_d.mem[s_q.wr] = din_i;
			s_d.wr = (s_q.wr == LAST) ? 8'h00 : s_q.wr + 8'h01;
		end
		if (do_pop) begin
			s_d.rd = (s_q.rd == LAST) ? 8'h00 : s_q.rd + 8'h01;
		end
		s_d.cnt = s_q.cnt + {7'h00, do_push} - {7'h00, do_pop};
		if (clr_i) begin
			s_d.wr = 8'h00;
			s_d.rd = 8'h00;
			s_d.cnt = 8'h00;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign dout_o = s_q.mem[s_q.rd];
	assign cnt_o = s_q.cnt;
	assign full_o = (s_q.cnt == 8'(`RIB_IB_DEPTH));
	assign empty_o = (s_q.cnt == 8'h00);
endmodule

// >>> rib_errq.sv
`include "rib_map.svh"
module rib_errq (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic clr_i,
	input wire logic push_i,
	input wire logic [15:0] code_i,
	input wire logic pop_i,
	output logic [15:0] head_o,
	output logic [4:0] cnt_o
);
	import rib_pkg::*;
	rib_eq_s_t s_q, s_d;

	// earliest errors are kept; slot 16 holds only the overflow code
	always_comb begin
		logic do_push;
		logic do_pop;
		do_pop = pop_i && (s_q.cnt != 5'h00);
		do_push = push_i && (s_q.cnt <= 5'(`RIB_EQ_DEPTH));
		s_d = s_q;
		if (do_push) begin
			s_d.mem[s_q.wr] = (s_q.cnt == 5'(`RIB_EQ_DEPTH)) ? `RIB_ERR_OVF : code_i;
			s_d.wr = s_q.wr + 4'h1;
		end
		if (do_pop) begin
			s_d.rd = s_q.rd + 4'h1;
		end
		s_d.cnt = s_q.cnt + {4'h0, do_push} - {4'h0, do_pop};
		if (clr_i) begin
			s_d.wr = 4'h0;
			s_d.rd = 4'h0;
			s_d.cnt = 5'h00;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// an empty queue answers zero
	assign head_o = (s_q.cnt == 5'h00) ? 16'h0000 : s_q.mem[s_q.rd];
	assign cnt_o = s_q.cnt;
endmodule

// >>> rib_top.sv
// Contract
// - received bytes go into 250-byte FIFO
// - end-or-identify stored as extra marker byte
// - full buffer holds not-ready-for-data asserted
// - one pop from full admits one byte
// - buffer emptied at power-up and device clear
// - send XOFF at 80 percent fill
// - send XON below 40 percent fill
// - clear-status zeroes events, errors, service request
// - clear-status cancels pending completion commands
// - event enable loads and reads back unchanged
// - event register query returns then clears
// - completion command sets event bit 0
// - completion query answers 1 after operations
// - reset restores power-up, blocks later commands
// - service enable loads and reads back
// - self-test answers 0/1, logs faults
// - wait blocks commands until operations finish
// - fault query returns and removes head
// - local, lockout and remote state commands
// - identity query returns identification word
// - error queue 15 codes then overflow
// - message-available bit follows output queue
//
// Implementation choices: register access over AXI4-Lite and the register addresses.
`include "rib_map.svh"
module rib_top (
	// clock and reset
	input wire logic CLK_SYS_I,
	input wire logic RST_N_I,
	// axi4-lite write
	input wire logic [7:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	// axi4-lite read
	input wire logic [7:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	// parallel instrument bus byte side
	input wire logic [7:0] PB_DATA_I,
	input wire logic PB_DAV_I,
	input wire logic PB_EOI_I,
	input wire logic PB_DEV_CLR_I,
	output logic PB_NRFD_O,
	// serial port byte side
	input wire logic [7:0] SER_RX_DATA_I,
	input wire logic SER_RX_VALID_I,
	input wire logic SER_FLOW_EN_I,
	output logic [7:0] SER_TX_DATA_O,
	output logic SER_TX_VALID_O,
	input wire logic SER_TX_READY_I,
	// device operations and self-test
	input wire logic OPS_BUSY_I,
	input wire logic [7:1] EVT_I,
	output logic DEV_RST_O,
	output logic ST_START_O,
	input wire logic ST_DONE_I,
	input wire logic ST_FAIL_I,
	input wire logic [15:0] ST_CODE_I,
	// status outputs
	output logic [7:0] STB_O,
	output rib_pkg::rib_rmt_t RMT_STATE_O
);
	import rib_pkg::*;
	rib_top_s_t s_q, s_d;
	rib_ent_t ib_din;
	rib_ent_t ib_dout;
	logic ib_push;
	logic ib_pop;
	logic ib_clr;
	logic [7:0] ib_cnt;
	logic ib_full;
	logic ib_empty;
	logic eq_clr;
	logic eq_push;
	logic eq_pop;
	logic [15:0] eq_code;
	logic [15:0] eq_head;
	logic [4:0] eq_cnt;
	logic pb_rdy;
	logic wr_go;
	logic rd_go;
	logic [7:0] stb;

	// serial bytes win the single push port, so the bus waits a cycle
	assign pb_rdy = !ib_full && !s_q.eoi_pend && !SER_RX_VALID_I;
	assign PB_NRFD_O = !pb_rdy;

	// writes are taken only with address and data together
	assign wr_go = S_AXI_AWVALID && S_AXI_WVALID && !s_q.bvalid;
	assign rd_go = S_AXI_ARVALID && !s_q.rvalid;
	assign S_AXI_AWREADY = wr_go;
	assign S_AXI_WREADY = wr_go;
	assign S_AXI_ARREADY = rd_go;

	// status byte: summary of enabled events, message available, service request
	always_comb begin
		stb = 8'h00;
		stb[`RIB_B_MAV] = s_q.mav;
		stb[`RIB_B_ESB] = |(s_q.esr & s_q.ese);
		stb[`RIB_B_RQS] = s_q.rqs;
	end

	// whole block state update
	always_comb begin
		logic [7:0] esr_set;
		logic esr_clr;
		logic exec;
		logic [7:0] arg;
		rib_op_t op;
		s_d = s_q;
		esr_set = {EVT_I, 1'b0};
		esr_clr = 1'b0;
		exec = 1'b0;
		ib_push = 1'b0;
		ib_pop = 1'b0;
		ib_din = '0;
		ib_clr = PB_DEV_CLR_I;
		eq_clr = 1'b0;
		eq_push = 1'b0;
		eq_pop = 1'b0;
		eq_code = 16'h0000;
		s_d.st_go = 1'b0;
		s_d.rst_go = 1'b0;
		op = rib_op_t'(S_AXI_WDATA[`RIB_F_OP]);
		arg = S_AXI_WDATA[`RIB_F_ARG];

		// byte intake; serial bytes cannot be held off, so a pending marker waits behind them
		if (SER_RX_VALID_I) begin
			ib_push = 1'b1;
			ib_din = '{mark: 1'b0, data: SER_RX_DATA_I};
			if (ib_full) begin
				eq_push = 1'b1;
				eq_code = `RIB_ERR_SER_OVF;
			end
		end else if (s_q.eoi_pend) begin
			if (!ib_full) begin
				ib_push = 1'b1;
				ib_din = '{mark: 1'b1, data: 8'h00};
				s_d.eoi_pend = 1'b0;
			end
		end else if (PB_DAV_I && pb_rdy) begin
			ib_push = 1'b1;
			ib_din = '{mark: 1'b0, data: PB_DATA_I};
			s_d.eoi_pend = PB_EOI_I;
		end
		if (PB_DEV_CLR_I) begin
			s_d.eoi_pend = 1'b0;
		end

		// software flow control toward the serial host
		if (s_q.tx_vld && SER_TX_READY_I) begin
			s_d.tx_vld = 1'b0;
		end
		if (!SER_FLOW_EN_I) begin
			s_d.xoff = 1'b0;
		end else if (!s_q.tx_vld) begin
			if (!s_q.xoff && ib_cnt >= 8'(`RIB_XOFF_LVL)) begin
				s_d.tx = `RIB_CH_XOFF;
				s_d.tx_vld = 1'b1;
				s_d.xoff = 1'b1;
			end else if (s_q.xoff && ib_cnt < 8'(`RIB_XON_LVL)) begin
				s_d.tx = `RIB_CH_XON;
				s_d.tx_vld = 1'b1;
				s_d.xoff = 1'b0;
			end
		end

		// write response
		if (s_q.bvalid && S_AXI_BREADY) begin
			s_d.bvalid = 1'b0;
		end
		// register reads; buffer and response reads consume what they return
		if (s_q.rvalid && S_AXI_RREADY) begin
			s_d.rvalid = 1'b0;
		end
		if (rd_go) begin
			s_d.rvalid = 1'b1;
			s_d.rresp = 2'b00;
			s_d.rdata = `RIB_RST_WORD;
			case (S_AXI_ARADDR)
				`RIB_A_RXBUF: begin
					s_d.rdata[`RIB_F_RXVLD] = !ib_empty;
					s_d.rdata[8:0] = ib_dout;
					ib_pop = 1'b1;
				end
				`RIB_A_STAT: begin
					s_d.rdata[`RIB_F_FILL] = ib_cnt;
					s_d.rdata[`RIB_F_XOFF] = s_q.xoff;
					s_d.rdata[`RIB_F_BUSY] = (s_q.st != RIB_ST_IDLE);
					s_d.rdata[`RIB_F_RMT] = s_q.rmt;
					s_d.rdata[`RIB_F_MAV] = s_q.mav;
				end
				`RIB_A_RESP: begin
					s_d.rdata = s_q.resp;
					s_d.mav = 1'b0;
				end
				`RIB_A_STB: begin
					s_d.rdata[15:0] = {s_q.esr, stb};
				end
				default: begin
					s_d.rresp = 2'b10;
				end
			endcase
		end

		// sequencer for commands that must wait
		case (s_q.st)
			RIB_ST_WAIT: begin
				if (!OPS_BUSY_I) begin
					s_d.st = RIB_ST_IDLE;
				end
			end
			RIB_ST_OPCQ: begin
				if (!OPS_BUSY_I) begin
					s_d.resp = 32'h0000_0001;
					s_d.mav = 1'b1;
					s_d.st = RIB_ST_IDLE;
				end
			end
			RIB_ST_RESET: begin
				if (!s_q.rst_go && !OPS_BUSY_I) begin
					s_d.st = RIB_ST_IDLE;
				end
			end
			RIB_ST_TEST: begin
				if (ST_DONE_I) begin
					s_d.resp = {31'h0000_0000, ST_FAIL_I};
					s_d.mav = 1'b1;
					s_d.st = RIB_ST_IDLE;
					if (ST_FAIL_I) begin
						eq_push = 1'b1;
						eq_code = ST_CODE_I;
					end
				end
			end
			default: begin
				s_d.st = RIB_ST_IDLE;
			end
		endcase

		// armed completion sets the event bit once operations are idle
		if (s_q.opc_arm && !OPS_BUSY_I) begin
			esr_set[`RIB_B_OPC] = 1'b1;
			s_d.opc_arm = 1'b0;
		end

		// register writes; commands other than clear-status are dropped unless idle
		if (wr_go) begin
			s_d.bvalid = 1'b1;
			s_d.bresp = 2'b00;
			case (S_AXI_AWADDR)
				`RIB_A_CMD: begin
					exec = S_AXI_WSTRB[0] && (s_q.st == RIB_ST_IDLE || op == RIB_OP_CLS);
					if (exec) begin
						case (op)
							RIB_OP_CLS: begin
								esr_clr = 1'b1;
								eq_clr = 1'b1;
								s_d.rqs = 1'b0;
								s_d.opc_arm = 1'b0;
								s_d.st = RIB_ST_IDLE;
							end
							RIB_OP_ESE: s_d.ese = arg;
							RIB_OP_ESEQ: s_d.resp = {24'h000000, s_q.ese};
							RIB_OP_ESRQ: begin
								s_d.resp = {24'h000000, s_q.esr};
								esr_clr = 1'b1;
							end
							RIB_OP_IDNQ: s_d.resp = `RIB_ID_WORD;
							RIB_OP_OPC: s_d.opc_arm = 1'b1;
							RIB_OP_OPCQ: s_d.st = RIB_ST_OPCQ;
							RIB_OP_RST: begin
								s_d.st = RIB_ST_RESET;
								s_d.rst_go = 1'b1;
								s_d.ese = `RIB_RST_BYTE;
								s_d.sre = `RIB_RST_BYTE;
								s_d.opc_arm = 1'b0;
								s_d.rmt = RIB_RM_LOCAL;
							end
							RIB_OP_SRE: s_d.sre = arg;
							RIB_OP_SREQ: s_d.resp = {24'h000000, s_q.sre};
							RIB_OP_TSTQ: begin
								s_d.st = RIB_ST_TEST;
								s_d.st_go = 1'b1;
							end
							RIB_OP_WAI: s_d.st = RIB_ST_WAIT;
							RIB_OP_FLTQ: begin
								s_d.resp = {16'h0000, eq_head};
								eq_pop = 1'b1;
							end
							RIB_OP_LOC: s_d.rmt = RIB_RM_LOCAL;
							RIB_OP_LLO: s_d.rmt = RIB_RM_LOCKOUT;
							RIB_OP_RMT: s_d.rmt = RIB_RM_REMOTE;
							default: s_d.rmt = s_q.rmt;
						endcase
						// immediate queries load the output queue now
						case (op)
							RIB_OP_ESEQ, RIB_OP_ESRQ, RIB_OP_IDNQ,
							RIB_OP_SREQ, RIB_OP_FLTQ: s_d.mav = 1'b1;
							default: s_d.mav = s_d.mav;
						endcase
					end
				end
				`RIB_A_ERRLOG: begin
					// hardware errors take priority over a software log write
					if (!eq_push) begin
						eq_push = 1'b1;
						eq_code = S_AXI_WDATA[15:0];
					end
				end
				default: begin
					s_d.bresp = 2'b10;
				end
			endcase
		end

		// events arriving with a clear are kept
		s_d.esr = (esr_clr ? `RIB_RST_BYTE : s_q.esr) | esr_set;
		// service request is sticky; judged on the next status, so clear-status also drops its own cause
		if (|(s_d.sre & {2'b00, |(s_d.esr & s_d.ese), s_d.mav, 4'h0})) begin
			s_d.rqs = 1'b1;
		end
	end

	always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// power-up reset empties both queues through their own reset
	rib_fifo u_ibuf (
		.clk_i(CLK_SYS_I),
		.rst_n_i(RST_N_I),
		.clr_i(ib_clr),
		.push_i(ib_push),
		.din_i(ib_din),
		.pop_i(ib_pop),
		.dout_o(ib_dout),
		.cnt_o(ib_cnt),
		.full_o(ib_full),
		.empty_o(ib_empty)
	);

	rib_errq u_errq (
		.clk_i(CLK_SYS_I),
		.rst_n_i(RST_N_I),
		.clr_i(eq_clr),
		.push_i(eq_push),
		.code_i(eq_code),
		.pop_i(eq_pop),
		.head_o(eq_head),
		.cnt_o(eq_cnt)
	);

	// outputs
	assign S_AXI_BVALID = s_q.bvalid;
	assign S_AXI_BRESP = s_q.bresp;
	assign S_AXI_RVALID = s_q.rvalid;
	assign S_AXI_RRESP = s_q.rresp;
	assign S_AXI_RDATA = s_q.rdata;
	assign SER_TX_DATA_O = s_q.tx;
	assign SER_TX_VALID_O = s_q.tx_vld;
	assign DEV_RST_O = s_q.rst_go;
	assign ST_START_O = s_q.st_go;
	assign STB_O = stb;
	assign RMT_STATE_O = s_q.rmt;
endmodule

// >>> rib_monitor.sv
`include "rib_map.svh"
module rib_monitor (
	// clock and reset
	input wire logic CLK_SYS_I,
	input wire logic RST_N_I,
	// register bus
	input wire logic S_AXI_AWVALID,
	input wire logic S_AXI_AWREADY,
	input wire logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [1:0] S_AXI_BRESP,
	input wire logic S_AXI_ARVALID,
	input wire logic S_AXI_ARREADY,
	input wire logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	input wire logic [31:0] S_AXI_RDATA,
	// byte sides
	input wire logic PB_DAV_I,
	input wire logic PB_EOI_I,
	input wire logic PB_NRFD_O,
	input wire logic [7:0] SER_TX_DATA_O,
	input wire logic SER_TX_VALID_O,
	input wire logic SER_TX_READY_I,
	input wire logic DEV_RST_O
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge CLK_SYS_I); endclocking
	default disable iff (!RST_N_I);
	// bus answers come one cycle after the take and stand until accepted
	a_write_answer: assert property (S_AXI_AWVALID && S_AXI_AWREADY |=> S_AXI_BVALID)
		else $error("write response missing");
	a_bresp_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
		else $error("write response dropped");
	a_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
		else $error("read response missing");
	a_rdata_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
		else $error("read data dropped");
	// an end-of-message byte is followed by its marker slot
	a_eoi_marker: assert property (PB_DAV_I && !PB_NRFD_O && PB_EOI_I |=> PB_NRFD_O)
		else $error("no hold-off for end marker");
	// only the two flow characters leave, held until taken
	a_flow_char: assert property (SER_TX_VALID_O |-> SER_TX_DATA_O inside {`RIB_CH_XOFF, `RIB_CH_XON})
		else $error("unexpected flow character");
	a_flow_hold: assert property (SER_TX_VALID_O && !SER_TX_READY_I |=> SER_TX_VALID_O && $stable(SER_TX_DATA_O))
		else $error("flow character dropped");
	a_rst_pulse: assert property (DEV_RST_O |=> !DEV_RST_O)
		else $error("device reset not a pulse");
	c_pb_held: cover property (PB_DAV_I && PB_NRFD_O);
	c_xoff: cover property (SER_TX_VALID_O && SER_TX_DATA_O == `RIB_CH_XOFF);
	c_xon: cover property (SER_TX_VALID_O && SER_TX_DATA_O == `RIB_CH_XON);
endmodule
bind rib_top rib_monitor i_mon (.*);

// >>> rib_host.sv
`include "rib_map.svh"
module rib_host (
	// hold-off and flow characters from the device
	input wire logic clk_i,
	input wire logic nrfd_i,
	input wire logic [7:0] tx_data_i,
	input wire logic tx_valid_i,
	output logic tx_ready_o,
	// bytes toward the device
	output logic [7:0] pb_data_o,
	output logic pb_dav_o,
	output logic pb_eoi_o,
	output logic [7:0] ser_data_o,
	output logic ser_valid_o
);
	timeunit 1ns;
	timeprecision 100ps;
	logic stop_q = 1'h0;
	int n_pb = 0;
	int n_ser = 0;
	initial begin
		{pb_dav_o, pb_eoi_o, ser_valid_o, tx_ready_o} = 4'h0;
		pb_data_o = 8'h5A;
		ser_data_o = 8'hA5;
	end
	// ready alternates so the device also sees a slow taker
	always @(posedge clk_i) begin
		tx_ready_o <= !tx_ready_o;
		if (tx_valid_i && tx_ready_o)
			stop_q <= (tx_data_i == `RIB_CH_XOFF);
	end
	// byte held until an edge with not-ready low; released data is inverted
	task pb_send(input int n, input logic eoi);
		for (int k = 0; k < n; k++) begin
			@(posedge clk_i);
			pb_data_o <= n_pb[7:0];
			pb_dav_o <= 1'h1;
			pb_eoi_o <= eoi && (k == n - 1);
			@(posedge clk_i iff nrfd_i === 1'h0);
			n_pb++;
			pb_dav_o <= 1'h0;
			pb_eoi_o <= 1'h0;
			pb_data_o <= ~pb_data_o;
		end
	endtask
	// one byte per two cycles, paused while stopped
	task ser_send(input int n);
		for (int k = 0; k < n; k++) begin
			@(posedge clk_i iff !stop_q);
			ser_data_o <= n_ser[7:0];
			ser_valid_o <= 1'h1;
			@(posedge clk_i);
			n_ser++;
			ser_valid_o <= 1'h0;
			ser_data_o <= ~ser_data_o;
		end
	endtask
endmodule

// >>> rib_top_test.sv
`include "rib_map.svh"
module rib_top_test;
	timeunit 1ns;
	timeprecision 100ps;
	import rib_pkg::*;
	logic CLK_SYS_I, RST_N_I, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY;
	logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID, PB_DAV_I, PB_EOI_I;
	logic PB_DEV_CLR_I, PB_NRFD_O, SER_RX_VALID_I, SER_FLOW_EN_I, SER_TX_VALID_O, SER_TX_READY_I;
	logic OPS_BUSY_I, DEV_RST_O, ST_START_O, ST_DONE_I, ST_FAIL_I;
	logic [1:0] S_AXI_BRESP, S_AXI_RRESP, rr;
	logic [7:0] S_AXI_AWADDR, S_AXI_ARADDR, PB_DATA_I, SER_RX_DATA_I, SER_TX_DATA_O, STB_O;
	logic [31:0] S_AXI_WDATA, S_AXI_RDATA, d;
	logic [3:0] S_AXI_WSTRB;
	logic [7:1] EVT_I;
	logic [15:0] ST_CODE_I;
	rib_rmt_t RMT_STATE_O;
	int miscompares = 0;
	int n_tests = 0;
	int n_rst = 0;
	int n_st = 0;
	// one-cycle pulses are counted here, so tasks can judge them later
	always @(posedge CLK_SYS_I) begin
		n_rst += (DEV_RST_O === 1'h1);
		n_st += (ST_START_O === 1'h1);
	end
	rib_top i_dut (.*);
	rib_host i_host (.clk_i(CLK_SYS_I), .nrfd_i(PB_NRFD_O), .tx_data_i(SER_TX_DATA_O), .tx_valid_i(SER_TX_VALID_O),
		.tx_ready_o(SER_TX_READY_I), .pb_data_o(PB_DATA_I), .pb_dav_o(PB_DAV_I), .pb_eoi_o(PB_EOI_I),
		.ser_data_o(SER_RX_DATA_I), .ser_valid_o(SER_RX_VALID_I));
	initial begin
		CLK_SYS_I = 1'h0;
		forever #2.5 CLK_SYS_I = ~CLK_SYS_I;
	end
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	// address and data offered together, each released when taken
	task wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge CLK_SYS_I);
		S_AXI_AWADDR <= a;
		S_AXI_WDATA <= v;
		{S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} <= 3'h7;
		@(posedge CLK_SYS_I iff S_AXI_AWREADY === 1'h1);
		{S_AXI_AWVALID, S_AXI_WVALID} <= 2'h0;
		@(posedge CLK_SYS_I iff S_AXI_BVALID === 1'h1);
		rr = S_AXI_BRESP;
		S_AXI_BREADY <= 1'h0;
	endtask
	task rd(input logic [7:0] a);
		@(posedge CLK_SYS_I);
		S_AXI_ARADDR <= a;
		{S_AXI_ARVALID, S_AXI_RREADY} <= 2'h3;
		@(posedge CLK_SYS_I iff S_AXI_ARREADY === 1'h1);
		S_AXI_ARVALID <= 1'h0;
		@(posedge CLK_SYS_I iff S_AXI_RVALID === 1'h1);
		d = S_AXI_RDATA;
		rr = S_AXI_RRESP;
		S_AXI_RREADY <= 1'h0;
	endtask
	task cmd(input rib_op_t op, input logic [7:0] arg);
		wr(`RIB_A_CMD, {16'h0000, arg, 4'h0, op});
	endtask
	task qry(input string nm, input rib_op_t op, input logic [31:0] e);
		cmd(op, 8'h00);
		rd(`RIB_A_RESP);
		chk(nm, e, d);
	endtask
	task t_regs;
		cmd(RIB_OP_ESE, 8'hA5);
		chk("wr_okay", 32'h0, {30'h0, rr});
		qry("ese", RIB_OP_ESEQ, 32'h0000_00A5);
		cmd(RIB_OP_SRE, 8'h3C);
		qry("sre", RIB_OP_SREQ, 32'h0000_003C);
		qry("idn", RIB_OP_IDNQ, `RIB_ID_WORD);
		rd(8'h1C);
		chk("unmapped", 32'h0000_0002, {30'h0, rr});
		wr(8'h1C, 32'h0000_0000);
		chk("unmapped_wr", 32'h0000_0002, {30'h0, rr});
		$display("t_regs done");
	endtask
	task t_esr;
		EVT_I <= 7'h04;
		@(posedge CLK_SYS_I);
		EVT_I <= 7'h00;
		qry("esr", RIB_OP_ESRQ, 32'h0000_0008);
		qry("esr_clr", RIB_OP_ESRQ, 32'h0000_0000);
		$display("t_esr done");
	endtask
	task t_opc;
		OPS_BUSY_I <= 1'h1;
		cmd(RIB_OP_OPC, 8'h00);
		rd(`RIB_A_STB);
		chk("opc_early", 32'h0, d & 32'h100);
		OPS_BUSY_I <= 1'h0;
		rd(`RIB_A_STB);
		chk("opc_done", 32'h100, d & 32'h100);
		chk("stb_esb", 32'h20, {24'h0, STB_O} & 32'h20);
		OPS_BUSY_I <= 1'h1;
		cmd(RIB_OP_OPCQ, 8'h00);
		rd(`RIB_A_STAT);
		chk("opcq_wait", 32'h0, d & 32'h1000);
		OPS_BUSY_I <= 1'h0;
		rd(`RIB_A_STAT);
		rd(`RIB_A_RESP);
		chk("opcq", 32'h1, d);
		OPS_BUSY_I <= 1'h1;
		cmd(RIB_OP_OPC, 8'h00);
		wr(`RIB_A_ERRLOG, 32'h0000_0065);
		cmd(RIB_OP_CLS, 8'h00);
		OPS_BUSY_I <= 1'h0;
		rd(`RIB_A_STB);
		chk("cls_status", 32'h0, d & 32'hFF40);
		chk("stb_rqs", 32'h0, {24'h0, STB_O} & 32'h40);
		qry("cls_errq", RIB_OP_FLTQ, 32'h0);
		$display("t_opc done");
	endtask
	task t_errq;
		for (int i = 0; i < 17; i++) wr(`RIB_A_ERRLOG, 32'h0100 + i);
		for (int i = 0; i < 15; i++) qry("fault", RIB_OP_FLTQ, 32'h0100 + i);
		qry("fault_ovf", RIB_OP_FLTQ, {16'h0, `RIB_ERR_OVF});
		qry("fault_empty", RIB_OP_FLTQ, 32'h0);
		$display("t_errq done");
	endtask
	task t_rmt;
		rib_op_t ops[3] = '{RIB_OP_LLO, RIB_OP_RMT, RIB_OP_LOC};
		rib_rmt_t st[3] = '{RIB_RM_LOCKOUT, RIB_RM_REMOTE, RIB_RM_LOCAL};
		for (int i = 0; i < 3; i++) begin
			cmd(ops[i], 8'h00);
			chk("remote_state", {30'h0, st[i]}, {30'h0, RMT_STATE_O});
		end
		$display("t_rmt done");
	endtask
	// commands that hold off later ones, then the self-test
	task t_seq;
		OPS_BUSY_I <= 1'h1;
		cmd(RIB_OP_WAI, 8'h00);
		cmd(RIB_OP_ESE, 8'h5A);
		rd(`RIB_A_STAT);
		chk("wai_busy", 32'h200, d & 32'h200);
		OPS_BUSY_I <= 1'h0;
		rd(`RIB_A_STAT);
		chk("wai_idle", 32'h0, d & 32'h200);
		qry("wai_refused", RIB_OP_ESEQ, 32'h0000_00A5);
		cmd(RIB_OP_RMT, 8'h00);
		OPS_BUSY_I <= 1'h1;
		cmd(RIB_OP_RST, 8'h00);
		cmd(RIB_OP_ESE, 8'h5A);
		rd(`RIB_A_STAT);
		chk("rst_busy", 32'h200, d & 32'h200);
		OPS_BUSY_I <= 1'h0;
		qry("rst_ese", RIB_OP_ESEQ, 32'h0000_0000);
		qry("rst_sre", RIB_OP_SREQ, 32'h0000_0000);
		chk("rst_remote", 32'h0, {30'h0, RMT_STATE_O});
		chk("rst_pulse", 32'h1, n_rst);
		for (int f = 0; f < 2; f++) begin
			cmd(RIB_OP_TSTQ, 8'h00);
			{ST_CODE_I, ST_FAIL_I, ST_DONE_I} <= {16'h007C, f[0], 1'h1};
			@(posedge CLK_SYS_I);
			ST_DONE_I <= 1'h0;
			rd(`RIB_A_RESP);
			chk("selftest", f, d);
		end
		chk("selftest_start", 32'h2, n_st);
		qry("selftest_log", RIB_OP_FLTQ, 32'h0000_007C);
		qry("selftest_log_once", RIB_OP_FLTQ, 32'h0);
		$display("t_seq done");
	endtask
	task t_pb;
		i_host.pb_send(2, 1'h1);
		rd(`RIB_A_RXBUF);
		chk("pb_byte", 32'h8000_0000, d);
		rd(`RIB_A_RXBUF);
		chk("pb_eoi", 32'h8000_0001, d);
		rd(`RIB_A_RXBUF);
		chk("pb_marker", 32'h8000_0100, d & 32'h8000_0100);
		i_host.pb_send(`RIB_IB_DEPTH, 1'h0);
		fork
			i_host.pb_send(1, 1'h0);
			begin
				repeat (10) @(posedge CLK_SYS_I);
				chk("pb_held", 32'd252, i_host.n_pb);
				chk("nrfd_full", 32'h1, {31'h0, PB_NRFD_O});
				rd(`RIB_A_RXBUF);
				chk("pb_first", 32'h8000_0002, d);
				repeat (4) @(posedge CLK_SYS_I);
				chk("pb_one_more", 32'd253, i_host.n_pb);
				chk("nrfd_again", 32'h1, {31'h0, PB_NRFD_O});
			end
		join
		PB_DEV_CLR_I <= 1'h1;
		@(posedge CLK_SYS_I);
		PB_DEV_CLR_I <= 1'h0;
		rd(`RIB_A_STAT);
		chk("clr_fill", 32'h0, d & 32'hFF);
		$display("t_pb done");
	endtask
	task t_ser;
		int p;
		int ns;
		p = 0;
		SER_FLOW_EN_I <= 1'h1;
		fork
			i_host.ser_send(230);
			begin
				for (int k = 0; k < 1000 && !i_host.stop_q; k++) @(posedge CLK_SYS_I);
				rd(`RIB_A_STAT);
				ns = i_host.n_ser;
				chk("xoff", 32'h100, d & 32'h100);
				chk("xoff_fill", 32'h1, {31'h0, d[7:0] >= `RIB_XOFF_LVL && d[7:0] < 8'd204});
				while (i_host.stop_q && p < 250) begin
					rd(`RIB_A_RXBUF);
					chk("ser_data", 32'h8000_0000 | p[7:0], d);
					p++;
				end
				chk("xon_fill", 32'h1, {31'h0, (ns - p) inside {98, 99}});
			end
		join
		$display("t_ser done");
	endtask
	task tally_and_finish;
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// a hang counts as a failure
	initial begin
		repeat (40000) @(posedge CLK_SYS_I);
		miscompares++;
		$display("ERROR watchdog expected done seen hang");
		tally_and_finish;
	end
	initial begin
		{S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY, RST_N_I} = 6'h0;
		{PB_DEV_CLR_I, SER_FLOW_EN_I, OPS_BUSY_I, ST_DONE_I, ST_FAIL_I} = 5'h0;
		{S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA, EVT_I, ST_CODE_I} = 'h0;
		S_AXI_WSTRB = 4'hF;
		repeat (8) @(posedge CLK_SYS_I);
		RST_N_I <= 1'h1;
		t_regs;
		t_esr;
		t_opc;
		t_errq;
		t_rmt;
		t_seq;
		t_pb;
		t_ser;
		tally_and_finish;
	end
endmodule
